// *** tzp_pkg.sv ***
// package of the timer zero block: register map, field layouts, reset values
// assumes an AHB-Lite fabric and a core clock equal to the instruction cycle
package tzp_pkg;

  localparam int TZP_CNT_W = 8;
  localparam int TZP_PRE_W = 8;
  localparam int TZP_RATE_W = 3;
  localparam int TZP_IRQ_W = 1;

  // byte offsets of the register words
  localparam logic [7:0] TZP_ADDR_COUNT = 8'h00;
  localparam logic [7:0] TZP_ADDR_CONFIG = 8'h04;
  localparam logic [7:0] TZP_ADDR_INTCTL = 8'h08;
  localparam logic [7:0] TZP_ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] TZP_ADDR_IRQ_MASK = 8'h10;

  // interrupt_control field positions and the irq status overflow bit
  localparam int TZP_ICTL_GLOBAL_INT_EN_BIT = 7;
  localparam int TZP_ICTL_OVF_IE_BIT = 5;
  localparam int TZP_ICTL_OVF_FLAG_BIT = 2;
  localparam int TZP_IRQ_OVF_BIT = 0;

  // reset values
  localparam logic [7:0] TZP_CFG_RST = 8'hff;
  localparam logic [7:0] TZP_ICTL_RST = 8'h00;
  localparam logic [7:0] TZP_CNT_RST = 8'h00;
  localparam logic [0:0] TZP_IRQ_MASK_RST = 1'h0;

  // instruction cycles without counting after a count write
  localparam logic [1:0] TZP_INHIBIT_CYCLES = 2'h2;

  localparam logic [1:0] TZP_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TZP_HRESP_OKAY = 2'h0;

  typedef enum logic [0:0] {
    TZP_BUS_IDLE = 1'b0,
    TZP_BUS_WAIT = 1'b1
  } tzp_bus_e;

  // timing_config layout, bit 7 down to bit 0
  typedef struct packed {
    logic pullup_dis;
    logic int_edge;
    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assignment;
    logic [TZP_RATE_W-1:0] rate_select_field;
  } tzp_cfg_s;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
  } tzp_req_s;

endpackage : tzp_pkg

// *** tzp_edge_sync.sv ***
// synchroniser and selectable edge detector for the external count input
// assumes the input may change at any time relative to the core clock
`timescale 1ns/1ps
`default_nettype none
module tzp_edge_sync (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pin and edge choice
  input wire logic din,
  input wire logic falling_sel,
  // one-cycle pulse on the chosen edge
  output logic edge_pulse
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // meta_ff feeds sync_ff only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // edge taken on the synchronised copy only
  assign edge_pulse = falling_sel ? (prev_ff & ~sync_ff) : (~prev_ff & sync_ff);

endmodule : tzp_edge_sync
`default_nettype wire

// *** tzp_timer.sv ***
// 8-bit timer/counter with prescaler shared with the watchdog, AHB-Lite slave
// assumes CORE_CLK is the instruction cycle clock and a single bus master
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tzp_timer
  import tzp_pkg::*;
#(
  parameter int CNT_W = TZP_CNT_W,
  parameter int PRE_W = TZP_PRE_W
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [1:0] HRESP,
  output logic [31:0] HRDATA,
  // count pin and core state
  input wire logic EXT_COUNT_IN,
  input wire logic SLEEP_MODE,
  // watchdog side
  input wire logic WATCHDOG_CLEAR_OP,
  input wire logic WATCHDOG_BASE_TICK,
  output logic WATCHDOG_PRESC_TICK,
  // interrupt
  output logic IRQ
);

  if (CNT_W != 8) begin : g_bad_cnt
    $error("tzp_timer: CNT_W must be 8");
  end
  if (PRE_W != 8) begin : g_bad_pre
    $error("tzp_timer: PRE_W must be 8 to reach 1:256");
  end

  tzp_bus_e bus_st_ff;
  tzp_req_s req_ff;
  tzp_cfg_s cfg_ff;
  logic [7:0] ictl_ff;
  logic [TZP_IRQ_W-1:0] irq_stat_ff;
  logic [TZP_IRQ_W-1:0] irq_mask_ff;
  logic [CNT_W-1:0] count_ff;
  logic [PRE_W-1:0] presc_ff;
  logic [1:0] inhibit_ff;
  logic wd_tick_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_mux;

  logic accept;
  logic do_acc;
  logic wr_cnt;
  logic wr_cfg;
  logic wr_ictl;
  logic wr_mask;
  logic rd_stat;
  logic ext_edge;
  logic tmr_src;
  logic presc_evt;
  logic [3:0] tap_exp;
  logic [PRE_W:0] tap_one;
  logic [PRE_W:0] tap_full;
  logic [PRE_W-1:0] tap_mask;
  logic tap_done;
  logic tmr_inc;
  logic presc_clr;
  logic ovf;

  // bus front end: one wait state so a read sees every earlier write
  assign accept = HSEL & HREADY & (HTRANS == TZP_HTRANS_NONSEQ);
  assign do_acc = (bus_st_ff == TZP_BUS_WAIT);
  assign wr_cnt = do_acc & req_ff.write & (req_ff.addr == TZP_ADDR_COUNT);
  assign wr_cfg = do_acc & req_ff.write & (req_ff.addr == TZP_ADDR_CONFIG);
  assign wr_ictl = do_acc & req_ff.write & (req_ff.addr == TZP_ADDR_INTCTL);
  assign wr_mask = do_acc & req_ff.write & (req_ff.addr == TZP_ADDR_IRQ_MASK);
  assign rd_stat = do_acc & ~req_ff.write & (req_ff.addr == TZP_ADDR_IRQ_STAT);

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bus_st_ff <= TZP_BUS_IDLE;
    end else begin
      unique case (bus_st_ff)
        TZP_BUS_IDLE: begin
          if (accept) begin
            bus_st_ff <= TZP_BUS_WAIT;
          end
        end
        TZP_BUS_WAIT: begin
          bus_st_ff <= TZP_BUS_IDLE;
        end
      endcase
    end
  end

  // HSEL/HTRANS qualify NONSEQ only, SEQ is ignored; only NONSEQ singles are expected
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      req_ff <= '0;
    end else if (accept) begin
      req_ff.write <= HWRITE;
      req_ff.addr <= {HADDR[7:2], 2'h0};
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (req_ff.addr)
      TZP_ADDR_COUNT: rd_mux = {{(32 - CNT_W){1'b0}}, count_ff};
      TZP_ADDR_CONFIG: rd_mux = {24'h00_0000, cfg_ff};
      TZP_ADDR_INTCTL: rd_mux = {24'h00_0000, ictl_ff};
      TZP_ADDR_IRQ_STAT: rd_mux = {{(32 - TZP_IRQ_W){1'b0}}, irq_stat_ff};
      TZP_ADDR_IRQ_MASK: rd_mux = {{(32 - TZP_IRQ_W){1'b0}}, irq_mask_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (do_acc & ~req_ff.write) begin
      hrdata_ff <= rd_mux;
    end
  end

  assign HREADYOUT = ~do_acc;
  assign HRESP = TZP_HRESP_OKAY;
  assign HRDATA = hrdata_ff;

  // configuration
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_ff <= tzp_cfg_s'(TZP_CFG_RST);
    end else if (wr_cfg) begin
      cfg_ff <= tzp_cfg_s'(HWDATA[7:0]);
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_mask_ff <= TZP_IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_ff <= HWDATA[TZP_IRQ_W-1:0];
    end
  end

  // count source
  tzp_edge_sync u_edge (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .din(EXT_COUNT_IN),
    .falling_sel(cfg_ff.source_edge_select),
    .edge_pulse(ext_edge)
  );

  // sleep stops the timer path only; the watchdog path keeps running
  assign tmr_src = ~SLEEP_MODE & (cfg_ff.clock_source_select ? ext_edge : 1'b1);

  // one prescaler, fed from whichever user owns it
  assign presc_evt = cfg_ff.prescaler_assignment ? WATCHDOG_BASE_TICK : tmr_src;

  // tap exponent: rate code for the watchdog, rate code plus one for the timer
  assign tap_exp = cfg_ff.prescaler_assignment ? {1'b0, cfg_ff.rate_select_field}
                                               : {1'b0, cfg_ff.rate_select_field} + 4'h1;
  assign tap_one = (PRE_W + 1)'(1) << tap_exp;
  assign tap_full = tap_one - (PRE_W + 1)'(1);
  assign tap_mask = tap_full[PRE_W-1:0];
  assign tap_done = presc_evt & ((presc_ff & tap_mask) == tap_mask);

  assign presc_clr = (wr_cnt & ~cfg_ff.prescaler_assignment)
                   | (WATCHDOG_CLEAR_OP & cfg_ff.prescaler_assignment);

  // not visible on the bus by design
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      presc_ff <= '0;
    end else if (presc_clr) begin
      presc_ff <= '0;
    end else if (presc_evt) begin
      presc_ff <= presc_ff + PRE_W'(1);
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wd_tick_ff <= 1'b0;
    end else begin
      wd_tick_ff <= cfg_ff.prescaler_assignment ? tap_done : WATCHDOG_BASE_TICK;
    end
  end
  assign WATCHDOG_PRESC_TICK = wd_tick_ff;

  // timer advance: undivided only when the watchdog owns the prescaler
  assign tmr_inc = (inhibit_ff == 2'h0) & ~wr_cnt
                 & (cfg_ff.prescaler_assignment ? tmr_src : tap_done);
  assign ovf = tmr_inc & (count_ff == {CNT_W{1'b1}});

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      inhibit_ff <= 2'h0;
    end else if (wr_cnt) begin
      inhibit_ff <= TZP_INHIBIT_CYCLES;
    end else if (inhibit_ff != 2'h0) begin
      inhibit_ff <= inhibit_ff - 2'h1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      count_ff <= TZP_CNT_RST;
    end else if (wr_cnt) begin
      count_ff <= HWDATA[CNT_W-1:0];
    end else if (tmr_inc) begin
      count_ff <= count_ff + CNT_W'(1);
    end
  end

  // overflow flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ictl_ff <= TZP_ICTL_RST;
    end else begin
      if (wr_ictl) begin
        ictl_ff <= HWDATA[7:0];
      end
      if (ovf) begin
        ictl_ff[TZP_ICTL_OVF_FLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_stat_ff <= '0;
    end else if (ovf) begin
      irq_stat_ff[TZP_IRQ_OVF_BIT] <= 1'b1;
    end else if (rd_stat) begin
      irq_stat_ff <= '0;
    end
  end

  assign IRQ = |(irq_stat_ff & irq_mask_ff);

  // checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  logic quiet;
  assign quiet = ~wr_cnt & ~wr_cfg & ~SLEEP_MODE & (inhibit_ff == 2'h0);

  sequence s_cnt_write;
    wr_cnt ##1 (!wr_cnt)[*2];
  endsequence

  sequence s_free_cycle;
    quiet & cfg_ff.prescaler_assignment & ~cfg_ff.clock_source_select;
  endsequence

  AST_TIMER_TICK: assert property (s_free_cycle |=> count_ff == $past(count_ff) + CNT_W'(1))
    else $error("timer mode did not advance once per cycle");

  AST_WRITE_INHIBIT: assert property (s_cnt_write |=> count_ff == $past(count_ff, 2))
    else $error("count advanced within two cycles of a write");

  AST_EXT_EDGE: assert property (quiet & cfg_ff.prescaler_assignment & cfg_ff.clock_source_select
      |=> count_ff == $past(count_ff) + CNT_W'($past(ext_edge)))
    else $error("counter mode did not follow external edges");

  AST_WATCHDOG_ONLY: assert property (cfg_ff.prescaler_assignment & ~presc_clr
      |=> presc_ff == $past(presc_ff) + PRE_W'($past(WATCHDOG_BASE_TICK)))
    else $error("watchdog prescaler disturbed by timer source");

  AST_TMR_DIVIDE: assert property (tmr_inc & ~cfg_ff.prescaler_assignment
      |-> (presc_ff & tap_mask) == tap_mask && tap_mask != '0)
    else $error("timer advanced without a full prescaler period");

  AST_DIV2_SPACING: assert property (tmr_inc & ~cfg_ff.prescaler_assignment & ~wr_cfg
      & (cfg_ff.rate_select_field == 3'h0) & ~presc_clr |=> !tmr_inc)
    else $error("timer counted undivided while owning the prescaler");

  AST_PRESC_CLR_WR: assert property (wr_cnt & ~cfg_ff.prescaler_assignment |=> presc_ff == '0)
    else $error("count write did not clear prescaler");

  AST_PRESC_CLR_WATCHDOG: assert property (WATCHDOG_CLEAR_OP & cfg_ff.prescaler_assignment
      |=> presc_ff == '0)
    else $error("watchdog clear did not clear prescaler");

  AST_WATCHDOG_RATE1: assert property (cfg_ff.prescaler_assignment & ~wr_cfg
      & (cfg_ff.rate_select_field == 3'h0)
      |=> WATCHDOG_PRESC_TICK == $past(WATCHDOG_BASE_TICK))
    else $error("watchdog rate code zero is not 1:1");

  AST_OVF_FLAG: assert property (ovf |=> ictl_ff[TZP_ICTL_OVF_FLAG_BIT] && irq_stat_ff[0])
    else $error("rollover did not set overflow flag");

  AST_SLEEP_FREEZE: assert property (SLEEP_MODE & ~wr_cnt
      & ~cfg_ff.prescaler_assignment |=> $stable(count_ff) && $stable(presc_ff))
    else $error("timer moved during sleep");

endmodule : tzp_timer
`default_nettype wire

// *** tzp_ext_src.sv ***
// model of the external count source driving the count pin
// assumes go is a one-cycle pulse set up by the bench after a clock edge
`timescale 1ns/1ps
`default_nettype none
module tzp_ext_src (
  // clock
  input wire logic clk,
  // request
  input wire logic go,
  input wire logic [3:0] n_edges,
  input wire logic [3:0] half_cyc,
  // pin side
  output logic pin,
  output logic busy
);
  // pin keeps its last level between bursts, as a driven source does
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < n_edges; i++) begin
          repeat (half_cyc) @(posedge clk);
          pin <= ~pin;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : tzp_ext_src
`default_nettype wire

// *** timer_zero_with_shared_prescaler_tb.sv ***
// self-checking bench for the timer zero block over AHB-Lite
// assumes the one slave drives hready and the pin model sits on the count input
`timescale 1ns/1ps
`default_nettype none
module timer_zero_with_shared_prescaler_tb
  import tzp_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic sleep = 1'b0;
  logic wclr = 1'b0;
  logic wtick = 1'b0;
  logic go = 1'b0;
  logic [3:0] ne = 4'h0;
  logic [3:0] hc = 4'h0;
  logic hrdy, wpt, irq, ext, busy;
  logic [1:0] hresp;
  logic [31:0] hrdata, rd, v;
  int bad_count = 0;
  int checks = 0;
  int npt = 0;
  int b;
  always #10 clk = ~clk;
  always @(posedge clk) if (wpt === 1'b1) npt <= npt + 1;
  tzp_timer DUT (.CORE_CLK(clk), .ARST_N(arst_n), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
    .HREADYOUT(hrdy), .HRESP(hresp), .HRDATA(hrdata), .EXT_COUNT_IN(ext),
    .SLEEP_MODE(sleep), .WATCHDOG_CLEAR_OP(wclr), .WATCHDOG_BASE_TICK(wtick),
    .WATCHDOG_PRESC_TICK(wpt), .IRQ(irq));
  tzp_ext_src SRC (.clk(clk), .go(go), .n_edges(ne), .half_cyc(hc), .pin(ext),
    .busy(busy));
  task automatic wrap_up;
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // ready is looked at mid-cycle, the value the next rising edge samples
  task automatic hwait;
    for (int n = 0; n < 20; n++) begin
      @(negedge clk);
      if (hrdy === 1'b1) begin
        rd = hrdata;
        @(posedge clk);
        return;
      end
    end
    bad_count++;
    wrap_up();
  endtask : hwait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= TZP_HTRANS_NONSEQ;
    hwrite <= w;
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rc
  task automatic pulses(input logic [3:0] n, input logic [3:0] h);
    ne <= n;
    hc <= h;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (int i = 0; busy !== 1'b0; i++) begin
      if (i > 300) begin
        bad_count++;
        wrap_up();
      end
      @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask : pulses
  task automatic ticks(input int n);
    repeat (n) begin
      wtick <= 1'b1;
      @(posedge clk);
      wtick <= 1'b0;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask : ticks
  task automatic wdclr;
    wclr <= 1'b1;
    @(posedge clk);
    wclr <= 1'b0;
    @(posedge clk);
  endtask : wdclr
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rc(TZP_ADDR_COUNT, 32'h0000_0000);
    rc(TZP_ADDR_CONFIG, 32'h0000_00ff);
    rc(TZP_ADDR_INTCTL, 32'h0000_0000);
    rc(TZP_ADDR_IRQ_STAT, 32'h0000_0000);
    rc(TZP_ADDR_IRQ_MASK, 32'h0000_0000);
    wr(8'h14, 32'h0000_00aa);
    rc(8'h14, 32'h0000_0000);
    chk({30'h0, hresp}, {30'h0, TZP_HRESP_OKAY});
    // timer mode, watchdog owns prescaler
    wr(TZP_ADDR_CONFIG, 32'h0000_0008);
    wr(TZP_ADDR_COUNT, 32'h0000_0040);
    rc(TZP_ADDR_COUNT, 32'h0000_0040);
    rc(TZP_ADDR_COUNT, 32'h0000_0043);
    sleep <= 1'b1;
    repeat (3) @(posedge clk);
    xfer(1'b0, TZP_ADDR_COUNT, 32'h0);
    v = rd;
    repeat (20) @(posedge clk);
    rc(TZP_ADDR_COUNT, v);
    sleep <= 1'b0;
    wr(TZP_ADDR_COUNT, 32'h0000_00fe);
    repeat (5) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(TZP_ADDR_IRQ_MASK, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    rc(TZP_ADDR_INTCTL, 32'h0000_0004);
    rc(TZP_ADDR_IRQ_STAT, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    rc(TZP_ADDR_IRQ_STAT, 32'h0000_0000);
    wr(TZP_ADDR_INTCTL, 32'h0000_0000);
    rc(TZP_ADDR_INTCTL, 32'h0000_0000);
    // timer owns prescaler: two counts over two full periods
    wdclr();
    for (int r = 0; r < 8; r++) begin
      wr(TZP_ADDR_CONFIG, 32'(r));
      xfer(1'b0, TZP_ADDR_COUNT, 32'h0);
      v = rd;
      repeat ((4 << r) - 3) @(posedge clk);
      rc(TZP_ADDR_COUNT, {24'h0, v[7:0] + 8'h02});
    end
    // sleep longer than one 1:256 period must freeze prescaler and count
    sleep <= 1'b1;
    xfer(1'b0, TZP_ADDR_COUNT, 32'h0);
    v = rd;
    repeat (300) @(posedge clk);
    rc(TZP_ADDR_COUNT, v);
    sleep <= 1'b0;
    // find the 1:256 period boundary, then a write mid-period must restart it
    xfer(1'b0, TZP_ADDR_COUNT, 32'h0);
    v = rd;
    for (int i = 0; i < 100 && rd === v; i++) xfer(1'b0, TZP_ADDR_COUNT, 32'h0);
    chk(rd, {24'h0, v[7:0] + 8'h01});
    repeat (150) @(posedge clk);
    wr(TZP_ADDR_COUNT, 32'h0000_0000);
    repeat (150) @(posedge clk);
    rc(TZP_ADDR_COUNT, 32'h0000_0000);
    // hand the prescaler to the watchdog in the safe order
    wdclr();
    wr(TZP_ADDR_COUNT, 32'h0000_0000);
    wr(TZP_ADDR_CONFIG, 32'h0000_000f);
    wdclr();
    // counter mode: three pin toggles each, rising then falling
    wr(TZP_ADDR_CONFIG, 32'h0000_0028);
    wr(TZP_ADDR_COUNT, 32'h0000_0000);
    pulses(4'h3, 4'h2);
    rc(TZP_ADDR_COUNT, 32'h0000_0002);
    wr(TZP_ADDR_CONFIG, 32'h0000_0038);
    wr(TZP_ADDR_COUNT, 32'h0000_0000);
    pulses(4'h3, 4'h9);
    rc(TZP_ADDR_COUNT, 32'h0000_0002);
    // watchdog side at 1:4, cleared in mid-period, then 1:1 once the timer owns the prescaler
    wr(TZP_ADDR_CONFIG, 32'h0000_000a);
    wdclr();
    b = npt;
    ticks(4);
    chk(32'(npt - b), 32'h0000_0001);
    ticks(2);
    wdclr();
    ticks(3);
    chk(32'(npt - b), 32'h0000_0001);
    ticks(1);
    chk(32'(npt - b), 32'h0000_0002);
    wr(TZP_ADDR_CONFIG, 32'h0000_0002);
    ticks(3);
    chk(32'(npt - b), 32'h0000_0005);
    wrap_up();
  end
endmodule : timer_zero_with_shared_prescaler_tb
`default_nettype wire
